// ---- common/cantxa_cfg.svh ----
`ifndef CANTXA_CFG_SVH
`define CANTXA_CFG_SVH
// Notes on behaviour
// R1 - After reset every buffer is unlocked and behaves as a receive buffer.
// R2 - Setting lock reserves the buffer for sending and blocks received bytes.
// R3 - Writing data byte 7 of a locked buffer raises its pending flag.
// R4 - Clearing lock on a pending buffer not on the bus cancels at once.
// R5 - Clearing lock while sending is ignored; software clears again afterwards.
// R6 - Software avoids clearing lock in the two bit times before start of frame.
// R7 - Abort sync reads set within two bit times, as internal request drops.
// R8 - Abort sync never drives a dominant pulse onto the transmit line.
// R9 - Software sets abort sync, polls for one, then clears lock.
// R10 - Software treats the abort as done when lock reads zero.
// R11 - Software clears abort sync afterwards; later sends need lock set.
// R12 - Clearing run lets the attempt end, then standby reports run zero.
// R13 - In standby clearing lock safely cancels that buffer's pending request.
// R14 - With no auto retransmit an errored frame is dropped, pending and busy clear.
// R15 - No auto retransmit keeps a frame pending after arbitration loss.
// R16 - Software waits for busy falling, then clears lock if still pending.
// R17 - Gap from busy falling to next start of frame exceeds software reaction.
// R18 - A successful attempt clears pending and busy.
// R19 - Clearing lock after arbitration loss aborts at once, clearing pending.
// R20 - Received identifier and data are written byte by byte into the buffer.
// R21 - Software sets phase segment two above 4 quanta or avoids multi-cycle writes.
// R22 - While busy, writes to the lock flag are ignored.
// R23 - A cancelled request never starts a frame from another or stale buffer.
// R24 - A request in the last intermission bit still sends own start of frame.

`define CANTXA_CSR_ADDR 12'h000
`define CANTXA_BUF_BASE 12'h040
`define CANTXA_IDX_IDH 4'h0
`define CANTXA_IDX_IDL 4'h1
`define CANTXA_IDX_D7 4'h9
`define CANTXA_IDX_BUFFER_CTRL_STATUS_REG 4'ha
`define CANTXA_CSR_RUN 0
`define CANTXA_CSR_SYNC 1
`define CANTXA_CSR_NO_AUTO_RETRANSMIT 3
`define CANTXA_BUFFER_CTRL_STATUS_REG_LOCK 0
`define CANTXA_BUFFER_CTRL_STATUS_REG_BUSY 1
`define CANTXA_BUFFER_CTRL_STATUS_REG_RDY 2
`define CANTXA_PREP_BITS 2
`define CANTXA_GAP_BITS 3
`define CANTXA_BIT_CYCLES 100
`endif

// ---- common/cantxa_pkg.sv ----
package cantxa_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_PREP = 2'b10,
        ST_SEND = 2'b11
    } cantxa_state_e;

    typedef struct packed {
        logic valid;
        logic [1:0] bufn;
        logic [3:0] idx;
        logic [7:0] data;
    } cantxa_rx_wr_s;

    typedef struct packed {
        logic valid;
        logic ok;
        logic error;
        logic arb_lost;
    } cantxa_outcome_s;
endpackage

// ---- design/cantxa_bit_tick.sv ----
`timescale 1ns/1ps
`include "cantxa_cfg.svh"
module cantxa_bit_tick #(
    parameter int BIT_CYCLES = `CANTXA_BIT_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    output logic o_tick
);
    localparam int CW = $clog2(BIT_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(BIT_CYCLES - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    wire wrap = (cnt_r == LAST);

    assign cnt_nxt = wrap ? '0 : cnt_r + CW'(1);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            o_tick <= wrap;
        end
    end
endmodule

// ---- design/cantxa_ctrl.sv ----
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "cantxa_cfg.svh"
module cantxa_ctrl #(
    parameter int NBUF = 3,
    parameter int BIT_CYCLES = `CANTXA_BIT_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire cantxa_pkg::cantxa_rx_wr_s i_rx_wr,
    input wire cantxa_pkg::cantxa_outcome_s i_outcome,
    input wire logic [3:0] i_tx_rd_idx,
    output logic [7:0] o_tx_rd_byte,
    output logic o_tx_start,
    output logic o_tx_sof,
    output logic [1:0] o_tx_buf,
    output logic o_tx_dominant
);
    localparam int SYNC_MAX = 2 * BIT_CYCLES + 4;

    // ****************************************
    // Bit timing
    // ****************************************
    logic bit_tick;

    cantxa_bit_tick #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tick (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .o_tick(bit_tick)
    );

    // ****************************************
    // APB decode
    // ****************************************
    function automatic logic buf_hit(input logic [11:0] a, input int b);
        logic [11:0] base;
        base = `CANTXA_BUF_BASE * 12'(b + 1);
        buf_hit = (a[11:6] == base[11:6]) && (a[1:0] == 2'b00)
            && (a[5:2] <= `CANTXA_IDX_BUFFER_CTRL_STATUS_REG);
    endfunction

    wire [3:0] reg_idx = i_paddr[5:2];
    wire csr_hit = (i_paddr == `CANTXA_CSR_ADDR);
    wire apb_do = i_psel && i_penable && o_pready;
    wire apb_wr = apb_do && i_pwrite;
    wire [7:0] wbyte = i_pwdata[7:0];

    logic [NBUF-1:0] hit;
    logic [NBUF-1:0] lock_r;
    logic [NBUF-1:0] busy_r;
    logic [NBUF-1:0] rdy_r;
    logic [7:0] mem [NBUF][10];

    logic run_req_r;
    logic run_stat_r;
    logic sync_req_r;
    logic sync_ack_r;
    logic no_auto_retransmit_r;

    cantxa_pkg::cantxa_state_e state_r;
    cantxa_pkg::cantxa_state_e state_nxt;
    logic [1:0] sel_r;
    logic [1:0] sel_nxt;
    logic [1:0] bcnt_r;
    logic [1:0] bcnt_nxt;
    logic start_nxt;

    // ****************************************
    // Per-buffer flags
    // ****************************************
    genvar gb;
    generate
        for (gb = 0; gb < NBUF; gb++) begin : g_buf
            wire mine = (sel_r == 2'(gb));
            wire wr_buffer_ctrl_status_reg = apb_wr && hit[gb] && (reg_idx == `CANTXA_IDX_BUFFER_CTRL_STATUS_REG);
            wire wr_d7 = apb_wr && hit[gb] && (reg_idx == `CANTXA_IDX_D7);
            wire done = i_outcome.valid && (state_r == cantxa_pkg::ST_SEND) && mine;
            wire drop = i_outcome.ok || (i_outcome.error && no_auto_retransmit_r); // R14 R15 R18
            wire lock_wr_ok = wr_buffer_ctrl_status_reg && !busy_r[gb]; // R22 R5
            wire cancel = lock_wr_ok && !wbyte[`CANTXA_BUFFER_CTRL_STATUS_REG_LOCK]; // R4 R13 R19
            wire lock_nxt = lock_wr_ok ? wbyte[`CANTXA_BUFFER_CTRL_STATUS_REG_LOCK] : lock_r[gb]; // R2
            wire busy_nxt = (start_nxt && (sel_nxt == 2'(gb))) ? 1'b1
                : (done ? 1'b0 : busy_r[gb]);
            wire rdy_nxt = (wr_d7 && lock_r[gb] && !busy_r[gb]) ? 1'b1 // R3
                : ((done && drop) || cancel) ? 1'b0 : rdy_r[gb];

            assign hit[gb] = buf_hit(i_paddr, gb);

            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    lock_r[gb] <= 1'b0; // R1
                    busy_r[gb] <= 1'b0;
                    rdy_r[gb] <= 1'b0;
                end else begin
                    lock_r[gb] <= lock_nxt;
                    busy_r[gb] <= busy_nxt;
                    rdy_r[gb] <= rdy_nxt;
                end
            end
        end
    endgenerate

    // ****************************************
    // Buffer RAM
    // ****************************************
    // Receive bytes win over a CPU write in the same cycle; software keeps
    // CPU writes to locked buffers, where no receive byte can land.
    wire [1:0] apb_buf = 2'(i_paddr[7:6] - 2'd1);
    wire apb_mem_wr = apb_wr && !csr_hit && (reg_idx < `CANTXA_IDX_BUFFER_CTRL_STATUS_REG)
        && (i_paddr[7:6] != 2'd0) && (32'(apb_buf) < NBUF) && hit[apb_buf];
    wire rx_ok = i_rx_wr.valid && (32'(i_rx_wr.bufn) < NBUF)
        && !lock_r[i_rx_wr.bufn] && (i_rx_wr.idx <= `CANTXA_IDX_D7); // R2

    always_ff @(posedge i_core_clk) begin
        if (rx_ok) begin
            mem[i_rx_wr.bufn][i_rx_wr.idx] <= i_rx_wr.data; // R20
        end else if (apb_mem_wr) begin
            mem[apb_buf][reg_idx] <= wbyte;
        end
    end

    // ****************************************
    // Transmit scheduler
    // ****************************************
    logic [1:0] pick;
    logic any_rdy;

    always_comb begin
        pick = 2'd0;
        any_rdy = 1'b0;
        for (int b = NBUF - 1; b >= 0; b--) begin
            if (rdy_r[b] && lock_r[b]) begin
                pick = 2'(b);
                any_rdy = 1'b1;
            end
        end
    end

    wire prep_last = bit_tick && (bcnt_r == 2'(`CANTXA_PREP_BITS - 1));
    wire gap_last = bit_tick && (bcnt_r == 2'(`CANTXA_GAP_BITS - 1));
    wire sel_live = rdy_r[sel_r] && lock_r[sel_r];

    always_comb begin
        state_nxt = state_r;
        sel_nxt = sel_r;
        bcnt_nxt = bcnt_r;
        start_nxt = 1'b0;
        unique case (state_r)
            cantxa_pkg::ST_IDLE: begin
                if (run_req_r && !sync_req_r && any_rdy) begin
                    state_nxt = cantxa_pkg::ST_PREP;
                    sel_nxt = pick;
                    bcnt_nxt = 2'd0;
                end
            end
            cantxa_pkg::ST_PREP: begin
                // A cancelled or synchronised request drops before start of
                // frame, so nothing stale is ever sent.
                if (!sel_live || sync_req_r || !run_req_r) begin
                    state_nxt = cantxa_pkg::ST_IDLE; // R23 R7
                end else if (prep_last) begin
                    state_nxt = cantxa_pkg::ST_SEND;
                    start_nxt = 1'b1;
                end else if (bit_tick) begin
                    bcnt_nxt = bcnt_r + 2'd1;
                end
            end
            cantxa_pkg::ST_SEND: begin
                if (i_outcome.valid) begin
                    state_nxt = cantxa_pkg::ST_WAIT; // R12
                    bcnt_nxt = 2'd0;
                end
            end
            cantxa_pkg::ST_WAIT: begin
                // Enforced gap plus preparation keeps the next start of frame
                // well clear of a lock clear issued at busy falling.
                if (gap_last) begin
                    state_nxt = cantxa_pkg::ST_IDLE; // R17
                end else if (bit_tick) begin
                    bcnt_nxt = bcnt_r + 2'd1;
                end
            end
        endcase
    end

    // The internal request is taken at start of frame, so only preparation
    // holds the ack back; waiting for a whole frame would break the bound.
    wire no_int_req = (state_r != cantxa_pkg::ST_PREP);
    wire sync_ack_nxt = sync_req_r && (sync_ack_r || no_int_req); // R7
    wire run_stat_nxt = run_req_r || (state_r == cantxa_pkg::ST_SEND); // R12

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= cantxa_pkg::ST_IDLE;
            sel_r <= 2'd0;
            bcnt_r <= 2'd0;
            sync_ack_r <= 1'b0;
            run_stat_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sel_r <= sel_nxt;
            bcnt_r <= bcnt_nxt;
            sync_ack_r <= sync_ack_nxt;
            run_stat_r <= run_stat_nxt;
        end
    end

    // ****************************************
    // Link outputs
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_start <= 1'b0;
            o_tx_sof <= 1'b0;
            o_tx_buf <= 2'd0;
            o_tx_dominant <= 1'b0;
            o_tx_rd_byte <= 8'h00;
        end else begin
            o_tx_start <= start_nxt;
            o_tx_sof <= start_nxt; // R24
            o_tx_buf <= sel_nxt;
            o_tx_dominant <= 1'b0; // R8
            o_tx_rd_byte <= mem[sel_r][i_tx_rd_idx];
        end
    end

    // ****************************************
    // Control register and APB answer
    // ****************************************
    wire csr_wr = apb_wr && csr_hit;
    wire mapped = csr_hit || (|hit);
    wire [7:0] csr_rd = {4'h0, no_auto_retransmit_r, 1'b0, sync_ack_r, run_stat_r};
    wire [7:0] buffer_ctrl_status_reg_rd = {5'h00, rdy_r[apb_buf], busy_r[apb_buf], lock_r[apb_buf]};
    wire [7:0] rd_byte = csr_hit ? csr_rd : !mapped ? 8'h00
        : (reg_idx == `CANTXA_IDX_BUFFER_CTRL_STATUS_REG) ? buffer_ctrl_status_reg_rd : mem[apb_buf][reg_idx];
    wire ready_nxt = i_psel && i_penable && !o_pready;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_req_r <= 1'b0;
            sync_req_r <= 1'b0;
            no_auto_retransmit_r <= 1'b0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            if (csr_wr) begin
                run_req_r <= i_pwdata[`CANTXA_CSR_RUN];
                sync_req_r <= i_pwdata[`CANTXA_CSR_SYNC];
                no_auto_retransmit_r <= i_pwdata[`CANTXA_CSR_NO_AUTO_RETRANSMIT];
            end
            o_pready <= ready_nxt;
            o_pslverr <= ready_nxt && !mapped;
            o_prdata <= {24'h00_0000, rd_byte};
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    wire wr_b0 = apb_wr && hit[0];

    a_reset_unlocked: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R1
        $rose(i_rst_n) |-> (lock_r == '0)) else $error("lock set after reset");
    a_req_on_byte7: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R3
        (wr_b0 && reg_idx == `CANTXA_IDX_D7 && lock_r[0] && !busy_r[0]) |=> rdy_r[0])
        else $error("byte 7 write did not raise pending");
    a_cancel_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R4
        (wr_b0 && reg_idx == `CANTXA_IDX_BUFFER_CTRL_STATUS_REG && !busy_r[0] && !wbyte[0]) |=> !rdy_r[0])
        else $error("lock clear did not cancel");
    a_busy_lock_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R22
        (wr_b0 && reg_idx == `CANTXA_IDX_BUFFER_CTRL_STATUS_REG && busy_r[0]) |=> $stable(lock_r[0]))
        else $error("lock changed while busy");
    a_sync_ack_time: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R7
        sync_req_r |-> ##[0:SYNC_MAX] sync_ack_r)
        else $error("abort sync not reported in time");
    a_ok_clears: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R18
        (state_r == cantxa_pkg::ST_SEND && i_outcome.valid && i_outcome.ok)
        |=> !rdy_r[$past(sel_r)] && !busy_r[$past(sel_r)])
        else $error("success left buffer pending");
    a_no_auto_retransmit_drop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R14
        (state_r == cantxa_pkg::ST_SEND && i_outcome.valid && i_outcome.error && no_auto_retransmit_r)
        |=> !rdy_r[$past(sel_r)]) else $error("errored frame kept pending");
    a_arb_keeps: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R15
        (state_r == cantxa_pkg::ST_SEND && i_outcome.valid && i_outcome.arb_lost
        && !i_outcome.error && !i_outcome.ok && !apb_wr)
        |=> rdy_r[$past(sel_r)]) else $error("arbitration loss dropped frame");
    a_start_sof: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R24
        o_tx_start |-> o_tx_sof && busy_r[o_tx_buf] && !o_tx_dominant)
        else $error("start without own start of frame");
    a_gap_after_busy: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R17
        $fell(|busy_r) |-> !o_tx_start [*8]) else $error("restart too soon after busy");
    a_standby_run: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R12
        (!run_req_r && state_r != cantxa_pkg::ST_SEND) |=> !run_stat_r)
        else $error("run still reported in standby");
    a_no_stale_start: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R23
        start_nxt |-> rdy_r[sel_r] && lock_r[sel_r]) else $error("stale frame started");
endmodule

// ---- test/cantxa_bus_node.sv ----
`timescale 1ns/1ps
// ****
// Far-side node: ends each attempt after a set delay
// ****
module cantxa_bus_node (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [1:0] i_kind,
    input wire logic [7:0] i_dly,
    output cantxa_pkg::cantxa_outcome_s o_outcome,
    output logic [3:0] o_rd_idx
);
    logic [7:0] cnt_r;
    logic busy_r;
    // Last data byte is watched so a stale or wrong buffer shows up
    assign o_rd_idx = 4'h9;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
            o_outcome <= '0;
        end else begin
            o_outcome <= '0;
            if (i_start) begin
                busy_r <= 1'b1;
                cnt_r <= i_dly;
            end else if (busy_r && cnt_r == 8'h00) begin
                busy_r <= 1'b0;
                o_outcome <= {1'b1, i_kind == 2'h0, i_kind == 2'h1, i_kind == 2'h2};
            end else if (busy_r) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule

// ---- test/can_tx_buffer_abort_control_bench.sv ----
`timescale 1ns/1ps
module can_tx_buffer_abort_control_bench;
    typedef struct packed {logic care; logic err; logic [31:0] d;} cantxa_note_s;
    typedef struct packed {logic [1:0] b; logic [7:0] d7;} cantxa_frame_s;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tx_start, tx_sof, tx_dom;
    logic [1:0] tx_buf;
    logic [3:0] rd_idx;
    logic [7:0] rd_byte;
    cantxa_pkg::cantxa_rx_wr_s rx_wr = '0;
    cantxa_pkg::cantxa_outcome_s outcome;
    logic [1:0] kind = 2'h0;
    logic [7:0] dly = 8'h10;
    int errors = 0;
    int n_compared = 0;
    logic [31:0] x = 32'h00012a4a;
    logic [31:0] v, d;
    logic [7:0] cur_d7 = 8'h00;
    cantxa_note_s apb_q[$];
    cantxa_frame_s tx_q[$];

    cantxa_ctrl #(.NBUF(3), .BIT_CYCLES(4)) uut (.i_core_clk(core_clk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_rx_wr(rx_wr), .i_outcome(outcome), .i_tx_rd_idx(rd_idx), .o_tx_rd_byte(rd_byte),
        .o_tx_start(tx_start), .o_tx_sof(tx_sof), .o_tx_buf(tx_buf), .o_tx_dominant(tx_dom));
    cantxa_bus_node node (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_start(tx_start),
        .i_kind(kind), .i_dly(dly), .o_outcome(outcome), .o_rd_idx(rd_idx));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    // ****
    // Reporting and comparison
    // ****
    task automatic wrap_up();
        if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bad(input string m);
        errors++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic fail(input string m);
        bad(m);
        wrap_up();
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) bad(m);
    endtask
    task automatic cmp_apb(input logic [31:0] r, input logic e);
        cantxa_note_s n;
        if (apb_q.size() == 0) begin
            bad("response without request");
            return;
        end
        n = apb_q.pop_front();
        chk({31'h0, e}, {31'h0, n.err}, "slave error");
        if (n.care) chk(r, n.d, "read data");
    endtask
    task automatic cmp_tx();
        cantxa_frame_s f;
        if (tx_q.size() == 0) begin
            bad("unexpected frame start");
            return;
        end
        f = tx_q.pop_front();
        chk({30'h0, tx_buf}, {30'h0, f.b}, "frame buffer");
        chk({31'h0, tx_sof}, 32'h1, "own start bit");
        chk({31'h0, tx_dom}, 32'h0, "dominant pulse");
        cur_d7 = f.d7;
    endtask
    always @(posedge core_clk) begin
        if (pready === 1'b1) cmp_apb(prdata, pslverr);
        if (tx_start === 1'b1) cmp_tx();
        if (outcome.valid === 1'b1) chk({24'h0, rd_byte}, {24'h0, cur_d7}, "frame byte");
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        fail("run limit");
    end

    // ****
    // Stimulus helpers
    // ****
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    function automatic logic [11:0] ba(input logic [1:0] b, input logic [11:0] off);
        return 12'h040 * {10'h0, b} + 12'h040 + off;
    endfunction
    // One access per byte: no multi-cycle read-modify-write on buffer RAM
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input cantxa_note_s n);
        int k;
        apb_q.push_back(n);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) fail("bus hung");
        v = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, '0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b1, 1'b0, e});
    endtask
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            apb(1'b0, a, 32'h0, '0);
            if ((v & m) === e) break;
        end
        if (k == lim) fail("poll limit");
    endtask
    task automatic fill(input logic [1:0] b, input logic go);
        int i;
        logic [7:0] d7;
        for (i = 0; i < 9; i++) wr(ba(b, 12'(4 * i)), rnd() & 32'hff);
        d7 = 8'(rnd());
        if (go) tx_q.push_back({b, d7});
        wr(ba(b, 12'h024), {24'h0, d7});
    endtask
    task automatic rx(input logic [1:0] b, input logic [7:0] db);
        rx_wr <= {1'b1, b, 4'h2, db};
        @(posedge core_clk);
        rx_wr <= '0;
        @(posedge core_clk);
    endtask
    task automatic wait_start();
        int k;
        for (k = 0; k < 300; k++) begin
            @(posedge core_clk);
            if (tx_start === 1'b1) break;
        end
        if (k == 300) fail("no frame start");
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(12'h000, 32'h0);
        for (int b = 0; b < 3; b++) rd(ba(2'(b), 12'h028), 32'h0);
        apb(1'b0, 12'h3fc, 32'h0, {1'b1, 1'b1, 32'h0});
        d = rnd();
        rx(2'h0, d[7:0]);
        rd(ba(2'h0, 12'h008), {24'h0, d[7:0]});
        wr(ba(2'h0, 12'h028), 32'h1);
        rx(2'h0, ~d[7:0]);
        rd(ba(2'h0, 12'h008), {24'h0, d[7:0]});
        fill(2'h0, 1'b0);
        rd(ba(2'h0, 12'h028), 32'h5);
        wr(ba(2'h0, 12'h028), 32'h0);
        rd(ba(2'h0, 12'h028), 32'h0);
        wr(12'h000, 32'h3);
        poll(12'h000, 32'h2, 32'h2, 3);
        wr(ba(2'h1, 12'h028), 32'h1);
        dly <= 8'h04 + 8'(rnd() & 32'hf);
        fill(2'h1, 1'b1);
        rd(ba(2'h1, 12'h028), 32'h5);
        wr(12'h000, 32'h1);
        wait_start();
        poll(ba(2'h1, 12'h028), 32'h7, 32'h1, 60);
        dly <= 8'h28;
        fill(2'h1, 1'b1);
        wait_start();
        wr(ba(2'h1, 12'h028), 32'h0);
        rd(ba(2'h1, 12'h028), 32'h7);
        wr(12'h000, 32'h3);
        poll(12'h000, 32'h2, 32'h2, 3);
        wr(12'h000, 32'h1);
        poll(ba(2'h1, 12'h028), 32'h7, 32'h1, 60);
        wr(12'h000, 32'h9);
        kind <= 2'h1;
        fill(2'h1, 1'b1);
        wait_start();
        poll(ba(2'h1, 12'h028), 32'h7, 32'h1, 60);
        kind <= 2'h2;
        dly <= 8'h0a;
        wr(ba(2'h2, 12'h028), 32'h1);
        fill(2'h2, 1'b1);
        wait_start();
        poll(ba(2'h2, 12'h028), 32'h2, 32'h0, 60);
        wr(ba(2'h2, 12'h028), 32'h0);
        rd(ba(2'h2, 12'h028), 32'h0);
        repeat (40) @(posedge core_clk);
        dly <= 8'h1e;
        wr(ba(2'h0, 12'h028), 32'h1);
        fill(2'h0, 1'b1);
        wait_start();
        wr(12'h000, 32'h8);
        rd(12'h000, 32'h9);
        poll(12'h000, 32'h1, 32'h0, 60);
        rd(ba(2'h0, 12'h028), 32'h5);
        wr(ba(2'h0, 12'h028), 32'h0);
        rd(ba(2'h0, 12'h028), 32'h0);
        repeat (40) @(posedge core_clk);
        if (apb_q.size() != 0 || tx_q.size() != 0) bad("results missing");
        wrap_up();
    end
endmodule
